//--- rtl/dspal_pkg.sv
// Shared constants and types for the dual serial port with address latch
package dspal_pkg;
    // Target addresses chosen by the select pin level
    localparam logic [6:0] ADDR_PIN_LOW = 7'h48;
    localparam logic [6:0] ADDR_PIN_FLOAT = 7'h4a;
    localparam logic [6:0] ADDR_PIN_HIGH = 7'h4b;
    // Select pin level codes
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_FLOAT = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;
    // Bit counting within a byte
    localparam logic [3:0] TW_LAST_BIT = 4'h7;
    localparam logic [3:0] TW_BYTE_DONE = 4'h8;
    localparam logic [2:0] LINK_LAST_BIT = 3'h7;
    // Matches seen before the address is latched
    localparam logic [1:0] HITS_BEFORE_LATCH = 2'h1;
    // Reset value of the synchroniser bank {scl, sda, cs_n, toggle}
    localparam logic [3:0] SYNC_IDLE = 4'he;
    // Measurement channels in cycling order
    typedef enum logic [3:0] {
        CH_SUPPLY,
        CH_INT_TEMP,
        CH_EXT_TEMP,
        CH_INPUTS_ONE_TWO,
        CH_ANALOG_INPUT_THREE,
        CH_ANALOG_INPUT_FOUR,
        CH_ANALOG_INPUT_FIVE,
        CH_ANALOG_INPUT_SIX,
        CH_ANALOG_INPUT_SEVEN,
        CH_ANALOG_INPUT_EIGHT
    } dspal_chan_t;
    // Two-wire engine states
    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ACK,
        S_WR,
        S_RD,
        S_MACK
    } dspal_tw_st_t;
endpackage

//--- rtl/dspal_link_if.sv
// Signals between the core and the four-wire shifter on the link clock
`timescale 1ns/10ps
interface dspal_link_if;
    logic [7:0] rx_byte;
    logic rx_tog;
    logic [7:0] tx_byte;
    logic dout_oe;
    logic lrst;
    modport link (output rx_byte, output rx_tog, output dout_oe, input tx_byte, input lrst);
    modport core (input rx_byte, input rx_tog, input dout_oe, output tx_byte, output lrst);
endinterface

//--- rtl/dspal_four_wire.sv
// Four-wire shifter running on the serial clock, framed by the select
`timescale 1ns/10ps
module dspal_four_wire (
    // Link clock and frame
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    // Core side
    dspal_link_if.link lk
);
    import dspal_pkg::*;

    logic [2:0] bcnt_ff, nxt_bcnt;
    logic [7:0] sh_ff, nxt_sh;
    logic [7:0] rxb_ff, nxt_rxb;
    logic tog_ff, nxt_tog;
    logic oe_ff, nxt_oe;

    ////////////////////////////////////////////////////////////////////////
    // Next values for shifting in and out
    always_comb begin
        nxt_bcnt = bcnt_ff + 3'h1;
        nxt_sh = {sh_ff[6:0], din}; // RULE_07
        nxt_rxb = rxb_ff;
        nxt_tog = tog_ff;
        if (bcnt_ff == LINK_LAST_BIT) begin
            nxt_rxb = nxt_sh;
            nxt_tog = ~tog_ff;
        end
        // Open drain: pull low only for a zero bit
        nxt_oe = ~lk.tx_byte[~bcnt_ff]; // RULE_06
    end

    // Frame state is cleared the moment the select goes high
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin // RULE_05
            bcnt_ff <= 3'h0;
            sh_ff <= 8'h00;
        end else begin
            bcnt_ff <= nxt_bcnt;
            sh_ff <= nxt_sh;
        end
    end

    // Hand-off survives frame end so the toggle never jumps spuriously
    always_ff @(posedge sclk or posedge lk.lrst) begin
        if (lk.lrst) begin
            rxb_ff <= 8'h00;
            tog_ff <= 1'b0;
        end else begin
            rxb_ff <= nxt_rxb;
            tog_ff <= nxt_tog;
        end
    end

    // Output bits change on the falling edge; link reset covers an idle clock
    always_ff @(negedge sclk or posedge cs_n or posedge lk.lrst) begin
        if (cs_n || lk.lrst) begin
            oe_ff <= 1'b0;
        end else begin
            oe_ff <= nxt_oe; // RULE_06
        end
    end

    assign lk.rx_byte = rxb_ff;
    assign lk.rx_tog = tog_ff;
    assign lk.dout_oe = oe_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the link side
    a_frame_quiet: assert property (@(posedge sclk) disable iff (lk.lrst) // RULE_05
        cs_n |-> !oe_ff)
        else $error("output driven outside frame");
    // Checked at the next clock, which usually falls in a later frame
    a_rx_capture: assert property (@(posedge sclk) disable iff (lk.lrst) // RULE_07
        !cs_n && bcnt_ff == LINK_LAST_BIT |=> rxb_ff[0] == $past(din) && tog_ff != $past(tog_ff))
        else $error("received byte not handed off");
endmodule

//--- rtl/dspal_port.sv
// Dual serial host port: two-wire target with address latch, four-wire port
`timescale 1ns/10ps
// Contract
// [RULE_01] Select pin level picks the target address
// [RULE_02] Latch address only after two matching transfers
// [RULE_03] Latch on eighth clock of second transfer
// [RULE_04] After latching, ignore select pin changes
// [RULE_05] Low select frames four-wire input and output
// [RULE_06] Four-wire output bits change on falling edge
// [RULE_07] Four-wire input bits sampled on rising edge
// [RULE_08] Alert on limit hit, polarity selectable
// [RULE_09] Cycle supply, temps, then inputs three-eight
// [RULE_10] Host keeps select high in two-wire use
// [RULE_11] Start two-wire; four-wire locks once selected
// [RULE_12] Only power cycle leaves four-wire mode
// [RULE_13] Select level arrives as two-bit code
// [RULE_14] Latch progress and lock cleared only by reset
module dspal_port (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Serial pins
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    output logic DOUT_OUT,
    output logic DOUT_OE,
    input wire logic [1:0] ADDR_SEL,
    // Byte stream to and from the register side
    output logic [7:0] RX_DATA,
    output logic RX_VALID,
    input wire logic [7:0] TX_DATA,
    // Port status
    output logic FOUR_WIRE,
    output logic ADDR_LATCHED,
    output logic [6:0] BUS_ADDR,
    // Alert
    input wire logic LIMIT_HIT,
    input wire logic ALERT_HIGH,
    output logic ALERT_OUT,
    output logic ALERT_OE,
    // Measurement sequencing
    input wire logic CYCLE_EN,
    input wire logic CONV_DONE,
    input wire logic DIODE_SEL,
    output dspal_pkg::dspal_chan_t CHANNEL
);
    import dspal_pkg::*;

    dspal_link_if lk();

    dspal_four_wire u_four_wire (
        .sclk(SCLK),
        .cs_n(CS_N),
        .din(SDA_IN),
        .lk(lk)
    );

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers: {scl, sda, cs_n, link toggle} and the select code
    logic [3:0] s1_ff, s2_ff, s3_ff, nxt_s1;
    logic [1:0] sel1_ff, sel2_ff;
    logic lrst_ff;

    always_comb begin
        nxt_s1 = {SCLK, SDA_IN, CS_N, lk.rx_tog};
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s1_ff <= SYNC_IDLE;
            s2_ff <= SYNC_IDLE;
            s3_ff <= SYNC_IDLE;
            sel1_ff <= SEL_FLOAT;
            sel2_ff <= SEL_FLOAT;
            lrst_ff <= 1'b1;
        end else begin
            s1_ff <= nxt_s1;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            sel1_ff <= ADDR_SEL; // RULE_13
            sel2_ff <= sel1_ff;
            lrst_ff <= 1'b0;
        end
    end

    // Edge and condition decode, second and third stages only
    logic scl_rise, scl_fall, bus_start, bus_stop, cs_fall, cs_high, rx_evt;
    assign scl_rise = s2_ff[3] & ~s3_ff[3];
    assign scl_fall = ~s2_ff[3] & s3_ff[3];
    assign bus_start = s2_ff[3] & s3_ff[3] & s3_ff[2] & ~s2_ff[2];
    assign bus_stop = s2_ff[3] & s3_ff[3] & ~s3_ff[2] & s2_ff[2];
    assign cs_fall = s3_ff[1] & ~s2_ff[1];
    assign cs_high = s2_ff[1];
    assign rx_evt = s2_ff[0] ^ s3_ff[0];

    ////////////////////////////////////////////////////////////////////////
    // Address selection
    logic [6:0] pin_addr, cur_addr;
    logic latched_ff, nxt_latched;
    logic [6:0] addr_ff, nxt_addr;

    always_comb begin
        case (sel2_ff)
            SEL_LOW: pin_addr = ADDR_PIN_LOW; // RULE_01
            SEL_HIGH: pin_addr = ADDR_PIN_HIGH;
            default: pin_addr = ADDR_PIN_FLOAT;
        endcase
        // Pin is followed live until the address is latched
        cur_addr = latched_ff ? addr_ff : pin_addr; // RULE_04
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-wire engine and byte outputs
    dspal_tw_st_t st_ff, nxt_st;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh, byte_in;
    logic [1:0] hits_ff, nxt_hits;
    logic rw_ff, nxt_rw, sda_oe_ff, nxt_sda_oe;
    logic [7:0] rxd_ff, nxt_rxd;
    logic rxv_ff, nxt_rxv;
    logic four_ff, nxt_four;
    logic [7:0] txh_ff, nxt_txh;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_hits = hits_ff;
        nxt_latched = latched_ff;
        nxt_addr = addr_ff;
        nxt_rw = rw_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_rxd = rxd_ff;
        nxt_rxv = 1'b0;
        byte_in = {sh_ff[6:0], s2_ff[2]};
        // Any select fall locks the four-wire port for good
        nxt_four = four_ff | cs_fall; // RULE_11 RULE_12 RULE_10
        // Transmit byte for the shifter moves only while the select is high or when a received-byte hand-off is seen
        nxt_txh = (cs_high || rx_evt) ? TX_DATA : txh_ff;
        if (four_ff) begin
            nxt_st = S_IDLE;
            nxt_sda_oe = 1'b0;
            if (rx_evt) begin
                nxt_rxd = lk.rx_byte; // RULE_07
                nxt_rxv = 1'b1;
            end
        end else if (bus_stop) begin
            nxt_st = S_IDLE;
            nxt_sda_oe = 1'b0;
        end else if (bus_start) begin
            nxt_st = S_ADDR;
            nxt_cnt = 4'h0;
            nxt_sda_oe = 1'b0;
        end else begin
            case (st_ff)
                S_ADDR: begin
                    if (scl_rise) begin
                        nxt_sh = byte_in;
                        nxt_cnt = cnt_ff + 4'h1;
                        // Eighth clock: count matches, latch on the second
                        if (cnt_ff == TW_LAST_BIT && byte_in[7:1] == cur_addr
                                && !latched_ff) begin
                            if (hits_ff == HITS_BEFORE_LATCH) begin // RULE_02
                                nxt_latched = 1'b1; // RULE_03
                                nxt_addr = pin_addr;
                            end else begin
                                nxt_hits = hits_ff + 2'h1;
                            end
                        end
                    end else if (scl_fall && cnt_ff == TW_BYTE_DONE) begin
                        if (sh_ff[7:1] == cur_addr) begin
                            nxt_rw = sh_ff[0];
                            nxt_sda_oe = 1'b1;
                            nxt_st = S_ACK;
                        end else begin
                            nxt_st = S_IDLE;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        nxt_cnt = 4'h0;
                        if (rw_ff) begin
                            nxt_sh = TX_DATA;
                            nxt_sda_oe = ~TX_DATA[7];
                            nxt_st = S_RD;
                        end else begin
                            nxt_sda_oe = 1'b0;
                            nxt_st = S_WR;
                        end
                    end
                end
                S_WR: begin
                    if (scl_rise) begin
                        nxt_sh = byte_in;
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (scl_fall && cnt_ff == TW_BYTE_DONE) begin
                        nxt_rxd = sh_ff;
                        nxt_rxv = 1'b1;
                        nxt_sda_oe = 1'b1;
                        nxt_st = S_ACK;
                    end
                end
                S_RD: begin
                    if (scl_rise) begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_ff == TW_BYTE_DONE) begin
                            nxt_sda_oe = 1'b0;
                            nxt_st = S_MACK;
                        end else begin
                            nxt_sh = {sh_ff[6:0], 1'b1};
                            nxt_sda_oe = ~sh_ff[6];
                        end
                    end
                end
                S_MACK: begin
                    // Low from the master asks for one more byte
                    if (scl_rise) begin
                        nxt_rw = ~s2_ff[2];
                    end else if (scl_fall) begin
                        nxt_cnt = 4'h0;
                        if (rw_ff) begin
                            nxt_sh = TX_DATA;
                            nxt_sda_oe = ~TX_DATA[7];
                            nxt_st = S_RD;
                        end else begin
                            nxt_st = S_IDLE;
                        end
                    end
                end
                default: nxt_st = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_ff <= S_IDLE;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            hits_ff <= 2'h0; // RULE_14
            latched_ff <= 1'b0;
            addr_ff <= ADDR_PIN_FLOAT;
            rw_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            rxd_ff <= 8'h00;
            rxv_ff <= 1'b0;
            four_ff <= 1'b0; // RULE_14
            txh_ff <= 8'h00;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            hits_ff <= nxt_hits;
            latched_ff <= nxt_latched;
            addr_ff <= nxt_addr;
            rw_ff <= nxt_rw;
            sda_oe_ff <= nxt_sda_oe;
            rxd_ff <= nxt_rxd;
            rxv_ff <= nxt_rxv;
            four_ff <= nxt_four;
            txh_ff <= nxt_txh;
        end
    end

    assign lk.tx_byte = txh_ff;
    assign lk.lrst = lrst_ff;

    ////////////////////////////////////////////////////////////////////////
    // Alert pin and channel sequencer
    logic alert_oe_ff, nxt_alert_oe;
    dspal_chan_t chan_ff, nxt_chan;

    always_comb begin
        // Open drain: active low pulls on a hit, active high pulls when clear
        nxt_alert_oe = LIMIT_HIT ^ ALERT_HIGH; // RULE_08
        nxt_chan = chan_ff;
        if (!CYCLE_EN) begin
            nxt_chan = CH_SUPPLY;
        end else if (CONV_DONE) begin
            case (chan_ff)
                CH_SUPPLY: nxt_chan = CH_INT_TEMP; // RULE_09
                CH_INT_TEMP: nxt_chan = DIODE_SEL ? CH_EXT_TEMP : CH_INPUTS_ONE_TWO;
                CH_EXT_TEMP: nxt_chan = CH_ANALOG_INPUT_THREE;
                CH_INPUTS_ONE_TWO: nxt_chan = CH_ANALOG_INPUT_THREE;
                CH_ANALOG_INPUT_THREE: nxt_chan = CH_ANALOG_INPUT_FOUR;
                CH_ANALOG_INPUT_FOUR: nxt_chan = CH_ANALOG_INPUT_FIVE;
                CH_ANALOG_INPUT_FIVE: nxt_chan = CH_ANALOG_INPUT_SIX;
                CH_ANALOG_INPUT_SIX: nxt_chan = CH_ANALOG_INPUT_SEVEN;
                CH_ANALOG_INPUT_SEVEN: nxt_chan = CH_ANALOG_INPUT_EIGHT;
                default: nxt_chan = CH_SUPPLY;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            alert_oe_ff <= 1'b0;
            chan_ff <= CH_SUPPLY;
        end else begin
            alert_oe_ff <= nxt_alert_oe;
            chan_ff <= nxt_chan;
        end
    end

    // Open-drain pins only ever pull low
    logic zero_ff;
    always_ff @(posedge CLK) begin
        zero_ff <= 1'b0;
    end

    assign SDA_OUT = zero_ff;
    assign SDA_OE = sda_oe_ff;
    assign DOUT_OUT = zero_ff;
    assign DOUT_OE = lk.dout_oe;
    assign RX_DATA = rxd_ff;
    assign RX_VALID = rxv_ff;
    assign FOUR_WIRE = four_ff;
    assign ADDR_LATCHED = latched_ff;
    assign BUS_ADDR = addr_ff;
    assign ALERT_OUT = zero_ff;
    assign ALERT_OE = alert_oe_ff;
    assign CHANNEL = chan_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the core side
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    a_addr_pin_map: assert property ($rose(latched_ff) |-> // RULE_01
        addr_ff == $past(pin_addr))
        else $error("latched address differs from pin level");
    a_latch_second: assert property ($rose(latched_ff) |-> // RULE_02
        $past(hits_ff) == HITS_BEFORE_LATCH)
        else $error("address latched before second match");
    a_latch_eighth: assert property ($rose(latched_ff) |-> // RULE_03
        $past(scl_rise) && $past(cnt_ff) == TW_LAST_BIT)
        else $error("address latched off the eighth clock");
    a_addr_frozen: assert property (latched_ff |=> // RULE_04
        latched_ff && $stable(addr_ff))
        else $error("latched address moved");
    a_lock_on_frame: assert property (cs_fall |=> four_ff) // RULE_11
        else $error("select fall did not lock four-wire");
    a_lock_kept: assert property (four_ff |=> four_ff) // RULE_12
        else $error("four-wire lock dropped");
    a_two_wire_mute: assert property (four_ff |=> ##1 !sda_oe_ff[*2]) // RULE_05
        else $error("two-wire drive while four-wire locked");
    a_alert_level: assert property (##1 alert_oe_ff == $past(LIMIT_HIT ^ ALERT_HIGH)) // RULE_08
        else $error("alert level wrong for polarity");
    a_chan_wrap: assert property (CYCLE_EN && CONV_DONE // RULE_09
        && chan_ff == CH_ANALOG_INPUT_EIGHT |=> chan_ff == CH_SUPPLY)
        else $error("cycle did not return to supply");
    a_chan_third: assert property (CYCLE_EN && CONV_DONE && chan_ff == CH_INT_TEMP // RULE_09
        |=> chan_ff == ($past(DIODE_SEL) ? CH_EXT_TEMP : CH_INPUTS_ONE_TWO))
        else $error("third slot wrong");

    c_latch: cover property ($rose(latched_ff));
    c_four_wire_byte: cover property (four_ff && rxv_ff);
    c_two_wire_read: cover property (st_ff == S_MACK ##1 st_ff == S_RD);
    c_cycle_wrap: cover property (chan_ff == CH_ANALOG_INPUT_EIGHT ##1 chan_ff == CH_SUPPLY);
endmodule

//--- verif/dspal_host_model.sv
// Host master model for the two-wire and four-wire serial port
`timescale 1ns/10ps
module dspal_host_model (
    // Pins the host drives
    output logic sclk,
    output logic cs_n,
    output logic sda_drv,
    // Wire levels the host sees
    input wire logic sda_line,
    input wire logic dout_line
);
    int rise_cnt;
    ////////////////////////////////////////
    // Idle: clock parked high, data left to the pull-up
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sda_drv = 1'b1;
        rise_cnt = 0;
    end
    // Start: data falls while the clock is high
    task automatic tw_start();
        #62.5 sda_drv = 1'b0;
        #31.25 sclk = 1'b0;
        rise_cnt = 0;
    endtask
    // Stop: data rises while the clock is high
    task automatic tw_stop();
        #31.25 sda_drv = 1'b0;
        #31.25 sclk = 1'b1;
        #31.25 sda_drv = 1'b1;
        #62.5;
    endtask
    // Byte MSB first; data changes mid-low so the synchroniser sees it settled
    task automatic tw_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #31.25 sda_drv = b[i];
            #31.25 sclk = 1'b1;
            rise_cnt++;
            #62.5 sclk = 1'b0;
        end
        #31.25 sda_drv = 1'b1;
        #31.25 sclk = 1'b1;
        ack = ~sda_line;
        #62.5 sclk = 1'b0;
    endtask
    // Read byte MSB first, then acknowledge for more or refuse for the last
    task automatic tw_read(input logic more, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #62.5 sclk = 1'b1;
            b[i] = sda_line;
            #62.5 sclk = 1'b0;
        end
        #31.25 sda_drv = ~more;
        #31.25 sclk = 1'b1;
        #62.5 sclk = 1'b0;
        #31.25 sda_drv = 1'b1;
    endtask
    // Frame of n clocks; the gap after it lets the next send byte reload
    task automatic fw_frame(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        cs_n = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            #31.25 sclk = 1'b0;
            #31.25 sda_drv = tx[i];
            #31.25 sclk = 1'b1;
            rx[i] = dout_line;
            #31.25;
        end
        #31.25 cs_n = 1'b1;
        sda_drv = 1'b1;
        #250;
    endtask
endmodule

//--- verif/dspal_port_tb.sv
// Self-checking bench for the dual serial port with address latch
`timescale 1ns/10ps
module dspal_port_tb;
    import dspal_pkg::*;
    logic clk, rst, limit_hit, alert_high, cycle_en, conv_done, diode_sel;
    logic [1:0] addr_sel;
    logic [7:0] tx_data, rx_data, rx_last;
    logic sda_out, sda_oe, dout_out, dout_oe, rx_valid, four_wire, addr_latched;
    logic alert_out, alert_oe;
    logic [6:0] bus_addr;
    dspal_chan_t channel;
    wire sclk, cs_n, sda_drv;
    // Open-drain wires with pull-ups
    wire sda_line = (sda_oe ? sda_out : 1'b1) & sda_drv;
    wire dout_line = dout_oe ? dout_out : 1'b1;
    int n_errors = 0, cmp_count = 0, rx_cnt = 0, latch_at = 0;
    ////////////////////////////////////////
    dspal_port uut (.CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SDA_IN(sda_line),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .DOUT_OUT(dout_out), .DOUT_OE(dout_oe),
        .ADDR_SEL(addr_sel), .RX_DATA(rx_data), .RX_VALID(rx_valid), .TX_DATA(tx_data),
        .FOUR_WIRE(four_wire), .ADDR_LATCHED(addr_latched), .BUS_ADDR(bus_addr),
        .LIMIT_HIT(limit_hit), .ALERT_HIGH(alert_high), .ALERT_OUT(alert_out),
        .ALERT_OE(alert_oe), .CYCLE_EN(cycle_en), .CONV_DONE(conv_done),
        .DIODE_SEL(diode_sel), .CHANNEL(channel));
    dspal_host_model host (.sclk(sclk), .cs_n(cs_n), .sda_drv(sda_drv),
        .sda_line(sda_line), .dout_line(dout_line));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Byte log; the one-cycle strobe is caught at the edge it stands for
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            rx_cnt++;
            rx_last = rx_data;
        end
    end
    // Host clock rise count at the moment the address latches
    always @(posedge addr_latched) latch_at = host.rise_cnt;
    // Watchdog well past the expected run of about 46 us
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
    ////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Reset held 8 cycles, then a margin before bus traffic
    task automatic do_reset();
        @(negedge clk) rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // Address byte, one data byte if acknowledged, then stop
    task automatic tw_write(input logic [6:0] a, input logic [7:0] d, input logic exp);
        logic ack;
        int n0;
        n0 = rx_cnt;
        host.tw_start();
        host.tw_byte({a, 1'b0}, ack);
        check(8'(ack), 8'(exp));
        if (ack === 1'b1) host.tw_byte(d, ack);
        host.tw_stop();
        check(8'(rx_cnt - n0), 8'(exp));
        if (exp) check(rx_last, d);
    endtask
    ////////////////////////////////////////
    task automatic test_reset_values();
        check(8'(four_wire), 8'h00);
        check(8'(addr_latched), 8'h00);
        check(8'(bus_addr), 8'(ADDR_PIN_FLOAT));
        check({5'h00, alert_out, sda_out, dout_out}, 8'h00);
        check(8'(channel), 8'(CH_SUPPLY));
        check({6'h00, sda_oe, dout_oe}, 8'h00);
    endtask
    // All four polarity and limit combinations
    task automatic test_alert();
        for (int i = 0; i < 4; i++) begin
            {alert_high, limit_hit} = 2'(i);
            repeat (3) @(negedge clk);
            // Pull low on a hit if active low, and while clear if active high
            check(8'(alert_oe), 8'((i == 1) || (i == 2)));
        end
        {alert_high, limit_hit} = 2'h0;
    endtask
    // Eleven steps so the wrap back to supply is seen, both third-slot choices
    task automatic test_cycle();
        dspal_chan_t seq [9];
        for (int d = 0; d < 2; d++) begin
            seq = '{CH_SUPPLY, CH_INT_TEMP, CH_EXT_TEMP, CH_ANALOG_INPUT_THREE,
                CH_ANALOG_INPUT_FOUR, CH_ANALOG_INPUT_FIVE, CH_ANALOG_INPUT_SIX,
                CH_ANALOG_INPUT_SEVEN, CH_ANALOG_INPUT_EIGHT};
            if (d == 0) seq[2] = CH_INPUTS_ONE_TWO;
            diode_sel = d[0];
            cycle_en = 1'b1;
            for (int k = 1; k < 12; k++) begin
                conv_done = 1'b1;
                @(negedge clk) conv_done = 1'b0;
                @(negedge clk);
                check(8'(channel), 8'(seq[k % 9]));
            end
            cycle_en = 1'b0;
            repeat (2) @(negedge clk);
            check(8'(channel), 8'(CH_SUPPLY));
        end
    endtask
    // Each pin level; a foreign address between the two hits must not count
    task automatic test_addr_latch();
        logic [6:0] addr [3];
        logic [1:0] code [3];
        addr = '{ADDR_PIN_LOW, ADDR_PIN_FLOAT, ADDR_PIN_HIGH};
        code = '{SEL_LOW, SEL_FLOAT, SEL_HIGH};
        for (int k = 0; k < 3; k++) begin
            addr_sel = code[k];
            do_reset();
            tw_write(addr[(k + 1) % 3], 8'h11, 1'b0);
            tw_write(addr[k], 8'h60 + 8'(k), 1'b1);
            tw_write(addr[(k + 2) % 3], 8'h22, 1'b0);
            check(8'(addr_latched), 8'h00);
            tw_write(addr[k], 8'h9c, 1'b1);
            check(8'(addr_latched), 8'h01);
            check(8'(latch_at), 8'h08);
            check(8'(bus_addr), 8'(addr[k]));
            @(negedge clk) addr_sel = code[(k + 1) % 3];
            repeat (8) @(negedge clk);
            tw_write(addr[(k + 1) % 3], 8'h33, 1'b0);
            tw_write(addr[k], 8'h44, 1'b1);
            check(8'(bus_addr), 8'(addr[k]));
        end
    endtask
    // Two whole frames, a cut-short one, then the lock against two-wire use
    task automatic test_four_wire();
        logic [7:0] rx;
        int n0;
        addr_sel = SEL_LOW;
        do_reset();
        tx_data = 8'ha5;
        n0 = rx_cnt;
        host.fw_frame(8'h3c, 8, rx);
        check(rx, 8'ha5);
        check(rx_last, 8'h3c);
        check(8'(four_wire), 8'h01);
        @(negedge clk) tx_data = 8'h5a;
        repeat (4) @(negedge clk);
        host.fw_frame(8'hc3, 8, rx);
        check(rx, 8'h5a);
        check(rx_last, 8'hc3);
        host.fw_frame(8'hff, 4, rx);
        check(8'(rx_cnt - n0), 8'h02);
        check(8'(dout_oe), 8'h00);
        tw_write(ADDR_PIN_LOW, 8'h55, 1'b0);
        check(8'(four_wire), 8'h01);
        do_reset();
        check(8'(four_wire), 8'h00);
        tw_write(ADDR_PIN_LOW, 8'h66, 1'b1);
    endtask
    // Two-wire read of two bytes: first acknowledged by the host, second refused
    task automatic test_tw_read();
        logic ack;
        logic [7:0] b;
        @(negedge clk) tx_data = 8'h96;
        host.tw_start();
        host.tw_byte({ADDR_PIN_LOW, 1'b1}, ack);
        check(8'(ack), 8'h01);
        host.tw_read(1'b1, b);
        check(b, 8'h96);
        host.tw_read(1'b0, b);
        check(b, 8'h96);
        host.tw_stop();
        check(8'(sda_oe), 8'h00);
    endtask
    ////////////////////////////////////////
    initial begin
        rst = 1'b1;
        {limit_hit, alert_high, cycle_en, conv_done, diode_sel} = 5'h00;
        addr_sel = SEL_LOW;
        tx_data = 8'h00;
        do_reset();
        test_reset_values();
        test_alert();
        test_cycle();
        test_addr_latch();
        test_four_wire();
        test_tw_read();
        complete_run();
    end
endmodule
